// >>> logic/gdo_cfg.v
// Gate drive configuration registers with routing and overcurrent handling.
//
// Overview of operation
// [RQ1] High-side source current comes from drive bits 7:4, 50mA to 640mA.
// [RQ2] Sink current on both sides is twice the programmed source current.
// [RQ3] Low-side source current comes from drive bits 3:0, same sixteen steps.
// [RQ4] Drain-source trip level from protection bits 7:4, 40mV up to 2000mV.
// [RQ5] Sense fault retry waits 4000us with bit 3 clear, 70us when set.
// [RQ6] Drain fault retry waits 4000us with bit 2 clear, 70us when set.
// [RQ7] Bits 1:0 pick one deglitch for both faults: 1.57/2.38/3.49/5.73us.
// [RQ8] Phase A high side: 000b low, 001b-110b inputs one-six, 111b Hi-Z.
// [RQ9] Phase A low side uses bits 2:0 with the same route encoding.
// [RQ10] Phase B high side uses bits 6:4 with the same route encoding.
// [RQ11] Phase B low side uses bits 2:0 with the same route encoding.
// [RQ12] Route 111b turns off source and sink of that driver.
// [RQ13] After a fault, gates float low when pulldown bit is 0, driven low if 1.
// [RQ14] Comparator one hysteresis 44mV when phase A bit 7 clear, none when set.
// [RQ15] Comparator two hysteresis 44mV when phase B bit 7 clear, none when set.
// [RQ16] Supply undervoltage level 5.3V with phase A bit 3 clear, 7.5V when set.
// [RQ17] Drive register resets to 0xFF, both strengths at maximum.
// [RQ18] Protection register resets to 0x00.
// [RQ19] Phase A routing register resets to 0x14.
// [RQ20] Phase B routing register resets to 0x25.
// [RQ21] Response mode 01b retries automatically instead of latching.
// [RQ22] Writing 110b to the lock field blocks all other register writes.
// [RQ23] Writing 011b to the lock field allows register writes again.
// [RQ24] Registers read back last written value or reset value, no side effects; the lock field at 06h reads back as zero.
`timescale 1ns/1ps
`include "gdo_cfg_regs.vh"

module gdo_cfg #(
  parameter RETRY_LONG_CYC  = `GDO_CYC(`GDO_RETRY_LONG_NS),
  parameter RETRY_SHORT_CYC = `GDO_CYC(`GDO_RETRY_SHORT_NS)
) (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Register port from the serial front end.
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output wire        write_locked_o,
  // Control inputs one to six, from pins.
  input  wire [5:0]  control_input_i,
  // Fault comparators from pins and response modes.
  input  wire        sense_overcurrent_i,
  input  wire        drain_source_overcurrent_i,
  input  wire [1:0]  sense_fault_response_i,
  input  wire [1:0]  drain_fault_response_i,
  input  wire        clear_fault_i,
  // Fault status.
  output wire [1:0]  fault_flag_o,
  output wire        fault_shutdown_o,
  // Gate outputs: A high, A low, B high, B low.
  output wire [3:0]  gate_o,
  output wire [3:0]  gate_oe_o,
  // Analog settings decoded from the registers.
  output reg  [9:0]  high_side_source_ma_o,
  output reg  [10:0] high_side_sink_ma_o,
  output reg  [9:0]  low_side_source_ma_o,
  output reg  [10:0] low_side_sink_ma_o,
  output reg  [11:0] drain_source_trip_mv_o,
  output wire        comparator_one_hysteresis_o,
  output wire        comparator_two_hysteresis_o,
  output wire        supply_undervoltage_level_o,
  output wire        post_fault_pulldown_select_o
);

  // Configuration registers.
  reg [7:0]  gate_drive_strength_r;
  reg [7:0]  overcurrent_protection_control_r;
  reg [7:0]  phase_a_input_select_r;
  reg [7:0]  phase_b_input_select_r;
  reg        locked_r;

  // Input synchronisers.
  reg [7:0]  sync1_r;
  reg [7:0]  sync2_r;

  wire       wr_ok;
  wire [3:0] high_side_source_strength;
  wire [3:0] low_side_source_strength;
  wire [3:0] drain_source_trip_level;
  wire [1:0] fault_deglitch_select;
  wire [2:0] phase_a_high_route;
  wire [2:0] phase_a_low_route;
  wire [2:0] phase_b_high_route;
  wire [2:0] phase_b_low_route;
  wire [11:0] route_all;
  wire [1:0] retry_short;
  wire [3:0] fault_mode;
  wire [1:0] fault_raw;
  wire [1:0] shut;
  reg  [9:0] deg_target;

  // Current code to milliamps.
  function [9:0] src_ma;
    input [3:0] code;
    begin
      case (code)
        4'h0: src_ma = 10'd50;
        4'h1: src_ma = 10'd60;
        4'h2: src_ma = 10'd70;
        4'h3: src_ma = 10'd80;
        4'h4: src_ma = 10'd100;
        4'h5: src_ma = 10'd120;
        4'h6: src_ma = 10'd140;
        4'h7: src_ma = 10'd160;
        4'h8: src_ma = 10'd200;
        4'h9: src_ma = 10'd240;
        4'hA: src_ma = 10'd280;
        4'hB: src_ma = 10'd320;
        4'hC: src_ma = 10'd400;
        4'hD: src_ma = 10'd480;
        4'hE: src_ma = 10'd560;
        default: src_ma = 10'd640;
      endcase
    end
  endfunction

  // Threshold code to millivolts.
  function [11:0] trip_mv;
    input [3:0] code;
    begin
      case (code)
        4'h0: trip_mv = 12'd40;
        4'h1: trip_mv = 12'd60;
        4'h2: trip_mv = 12'd80;
        4'h3: trip_mv = 12'd120;
        4'h4: trip_mv = 12'd160;
        4'h5: trip_mv = 12'd200;
        4'h6: trip_mv = 12'd240;
        4'h7: trip_mv = 12'd320;
        4'h8: trip_mv = 12'd400;
        4'h9: trip_mv = 12'd480;
        4'hA: trip_mv = 12'd600;
        4'hB: trip_mv = 12'd720;
        4'hC: trip_mv = 12'd960;
        4'hD: trip_mv = 12'd1200;
        4'hE: trip_mv = 12'd1600;
        default: trip_mv = 12'd2000;
      endcase
    end
  endfunction

  // Field views of the registers.
  assign high_side_source_strength = gate_drive_strength_r[`GDO_HI_MSB:`GDO_HI_LSB];
  assign low_side_source_strength  = gate_drive_strength_r[`GDO_LO_MSB:`GDO_LO_LSB];
  assign drain_source_trip_level   = overcurrent_protection_control_r[`GDO_HI_MSB:`GDO_HI_LSB];
  assign fault_deglitch_select     = overcurrent_protection_control_r[`GDO_DEG_MSB:`GDO_DEG_LSB];
  assign phase_a_high_route = phase_a_input_select_r[`GDO_ROUTE_HI_MSB:`GDO_ROUTE_HI_LSB]; // RQ8
  assign phase_a_low_route  = phase_a_input_select_r[`GDO_ROUTE_LO_MSB:`GDO_ROUTE_LO_LSB]; // RQ9
  assign phase_b_high_route = phase_b_input_select_r[`GDO_ROUTE_HI_MSB:`GDO_ROUTE_HI_LSB]; // RQ10
  assign phase_b_low_route  = phase_b_input_select_r[`GDO_ROUTE_LO_MSB:`GDO_ROUTE_LO_LSB]; // RQ11
  assign route_all = {phase_b_low_route, phase_b_high_route, phase_a_low_route, phase_a_high_route};

  // Static settings straight from register bits.
  assign comparator_one_hysteresis_o  = phase_a_input_select_r[`GDO_HYST_BIT]; // RQ14
  assign comparator_two_hysteresis_o  = phase_b_input_select_r[`GDO_HYST_BIT]; // RQ15
  assign supply_undervoltage_level_o  = phase_a_input_select_r[`GDO_FLAG_BIT]; // RQ16
  assign post_fault_pulldown_select_o = phase_b_input_select_r[`GDO_FLAG_BIT];
  assign write_locked_o = locked_r;

  // Writes other than the lock field are dropped while locked.
  assign wr_ok = reg_wr_i & ~locked_r; // RQ22
  // Register writes and the write lock.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      gate_drive_strength_r            <= `GDO_RST_DRIVE; // RQ17
      overcurrent_protection_control_r <= `GDO_RST_PROT; // RQ18
      phase_a_input_select_r           <= `GDO_RST_SELA; // RQ19
      phase_b_input_select_r           <= `GDO_RST_SELB; // RQ20
      locked_r                         <= 1'b0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == `GDO_ADDR_LOCK)
        if (reg_wdata_i[`GDO_LOCK_MSB:`GDO_LOCK_LSB] == `GDO_LOCK_SET)
          locked_r <= 1'b1; // RQ22
        else if (reg_wdata_i[`GDO_LOCK_MSB:`GDO_LOCK_LSB] == `GDO_LOCK_CLEAR)
          locked_r <= 1'b0; // RQ23
      if (wr_ok && reg_addr_i == `GDO_ADDR_DRIVE)
        gate_drive_strength_r <= reg_wdata_i;
      if (wr_ok && reg_addr_i == `GDO_ADDR_PROT)
        overcurrent_protection_control_r <= reg_wdata_i;
      if (wr_ok && reg_addr_i == `GDO_ADDR_SELA)
        phase_a_input_select_r <= reg_wdata_i;
      if (wr_ok && reg_addr_i == `GDO_ADDR_SELB)
        phase_b_input_select_r <= reg_wdata_i;
    end
  end

  // Read data, one cycle after the read strobe; unmapped reads give zero.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      case (reg_addr_i) // RQ24
        `GDO_ADDR_DRIVE: reg_rdata_o <= gate_drive_strength_r;
        `GDO_ADDR_PROT:  reg_rdata_o <= overcurrent_protection_control_r;
        `GDO_ADDR_SELA:  reg_rdata_o <= phase_a_input_select_r;
        `GDO_ADDR_SELB:  reg_rdata_o <= phase_b_input_select_r;
        default:         reg_rdata_o <= 8'h00;
      endcase
  end

  // Drive currents and trip level, registered.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      high_side_source_ma_o  <= 10'd0;
      high_side_sink_ma_o    <= 11'd0;
      low_side_source_ma_o   <= 10'd0;
      low_side_sink_ma_o     <= 11'd0;
      drain_source_trip_mv_o <= 12'd0;
    end
    else
    begin
      high_side_source_ma_o  <= src_ma(high_side_source_strength); // RQ1
      high_side_sink_ma_o    <= {src_ma(high_side_source_strength), 1'b0}; // RQ2
      low_side_source_ma_o   <= src_ma(low_side_source_strength); // RQ3
      low_side_sink_ma_o     <= {src_ma(low_side_source_strength), 1'b0}; // RQ2
      drain_source_trip_mv_o <= trip_mv(drain_source_trip_level); // RQ4
    end
  end

  // Two-stage synchronisers for pin inputs.
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end
    else
    begin
      sync1_r <= {drain_source_overcurrent_i, sense_overcurrent_i, control_input_i};
      sync2_r <= sync1_r;
    end
  end

  // Shared deglitch length in cycles.
  always @*
  begin
    case (fault_deglitch_select) // RQ7
      2'h0: deg_target = `GDO_DEG0_CYC;
      2'h1: deg_target = `GDO_DEG1_CYC;
      2'h2: deg_target = `GDO_DEG2_CYC;
      default: deg_target = `GDO_DEG3_CYC;
    endcase
  end

  // Fault index 0 is current sense, index 1 is drain-source.
  assign fault_raw   = sync2_r[7:6];
  assign fault_mode  = {drain_fault_response_i, sense_fault_response_i};
  assign retry_short = {overcurrent_protection_control_r[`GDO_DRAIN_RETRY],
                        overcurrent_protection_control_r[`GDO_SENSE_RETRY]};

  // Per-fault deglitch, latch, retry and report.
  genvar f;
  generate
    for (f = 0; f < 2; f = f + 1)
    begin : g_fault
      reg  [9:0]  deg_r;
      reg  [19:0] retry_r;
      reg         shut_r;
      reg         flag_r;
      wire [1:0]  mode = fault_mode[2*f+1:2*f];
      wire        hit  = fault_raw[f] && (deg_r == deg_target);

      // Deglitch counts cycles of a steady high comparator.
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          deg_r <= 10'd0;
        else if (!fault_raw[f])
          deg_r <= 10'd0;
        else if (deg_r < deg_target)
          deg_r <= deg_r + 10'd1; // RQ7
      end

      // Shutdown state; a new hit wins over a clear in the same cycle.
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          shut_r  <= 1'b0;
          flag_r  <= 1'b0;
          retry_r <= 20'd0;
        end
        else
        begin
          if (hit && mode != 2'h3)
            flag_r <= 1'b1;
          else if (clear_fault_i)
            flag_r <= 1'b0;
          if (hit && (mode == `GDO_MODE_LATCH || mode == `GDO_MODE_RETRY))
          begin
            shut_r  <= 1'b1;
            retry_r <= retry_short[f] ? RETRY_SHORT_CYC[19:0] : RETRY_LONG_CYC[19:0]; // RQ5 RQ6
          end
          else if (shut_r && mode == `GDO_MODE_RETRY)
          begin
            if (retry_r <= 20'd1)
            begin
              shut_r  <= 1'b0; // RQ21
              flag_r  <= 1'b0;
            end
            retry_r <= retry_r - 20'd1;
          end
          else if (clear_fault_i || mode == `GDO_MODE_REPORT || mode == 2'h3)
            shut_r <= 1'b0;
        end
      end
      assign shut[f]         = shut_r;
      assign fault_flag_o[f] = flag_r;
    end
  endgenerate
  assign fault_shutdown_o = |shut;

  // Per-driver routing of the synchronised control inputs.
  genvar d;
  generate
    for (d = 0; d < 4; d = d + 1)
    begin : g_drv
      wire [2:0] sel = route_all[3*d+2:3*d];
      reg        level_r;
      reg        drive_r;
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
        begin
          level_r <= 1'b0;
          drive_r <= 1'b0;
        end
        else if (fault_shutdown_o)
        begin
          level_r <= 1'b0;
          drive_r <= post_fault_pulldown_select_o; // RQ13
        end
        else if (sel == `GDO_ROUTE_OFF)
        begin
          level_r <= 1'b0;
          drive_r <= 1'b0; // RQ12
        end
        else if (sel == `GDO_ROUTE_LOW)
        begin
          level_r <= 1'b0;
          drive_r <= 1'b1;
        end
        else
        begin
          level_r <= sync2_r[sel - 3'd1]; // RQ8 RQ9 RQ10 RQ11
          drive_r <= 1'b1;
        end
      end
      // Each driver owns its level and enable flops, so every output bit has one driver.
      assign gate_o[d]    = level_r;
      assign gate_oe_o[d] = drive_r;
    end
  endgenerate

endmodule // gdo_cfg

// >>> logic/gdo_cfg_regs.vh
// Offsets, field positions, reset values and timing counts of the gate drive configuration slice.
`ifndef GDO_CFG_REGS_VH
`define GDO_CFG_REGS_VH

// Register offsets.
`define GDO_ADDR_LOCK      8'h06
`define GDO_ADDR_DRIVE     8'h08
`define GDO_ADDR_PROT      8'h09
`define GDO_ADDR_SELA      8'h0A
`define GDO_ADDR_SELB      8'h0B

// Reset values.
`define GDO_RST_DRIVE      8'hFF
`define GDO_RST_PROT       8'h00
`define GDO_RST_SELA       8'h14
`define GDO_RST_SELB       8'h25

// Write protection field and its codes.
`define GDO_LOCK_MSB       6
`define GDO_LOCK_LSB       4
`define GDO_LOCK_SET       3'h6
`define GDO_LOCK_CLEAR     3'h3

// Field positions.
`define GDO_HI_MSB         7
`define GDO_HI_LSB         4
`define GDO_LO_MSB         3
`define GDO_LO_LSB         0
`define GDO_SENSE_RETRY    3
`define GDO_DRAIN_RETRY    2
`define GDO_DEG_MSB        1
`define GDO_DEG_LSB        0
`define GDO_ROUTE_HI_MSB   6
`define GDO_ROUTE_HI_LSB   4
`define GDO_ROUTE_LO_MSB   2
`define GDO_ROUTE_LO_LSB   0
`define GDO_HYST_BIT       7
`define GDO_FLAG_BIT       3

// Route codes.
`define GDO_ROUTE_LOW      3'h0
`define GDO_ROUTE_OFF      3'h7

// Fault response modes.
`define GDO_MODE_LATCH     2'h0
`define GDO_MODE_RETRY     2'h1
`define GDO_MODE_REPORT    2'h2

// Timing in ns and cycle counts, least times rounded up.
`define GDO_CLK_NS         8
`define GDO_DEG0_NS        1570
`define GDO_DEG1_NS        2380
`define GDO_DEG2_NS        3490
`define GDO_DEG3_NS        5730
`define GDO_RETRY_LONG_NS  4000000
`define GDO_RETRY_SHORT_NS 70000
`define GDO_CYC(ns)        (((ns) + `GDO_CLK_NS - 1) / `GDO_CLK_NS)

// Deglitch lengths in cycles, rounded up and sized for the 10-bit counter.
`define GDO_DEG0_CYC       10'h0C5
`define GDO_DEG1_CYC       10'h12A
`define GDO_DEG2_CYC       10'h1B5
`define GDO_DEG3_CYC       10'h2CD

`endif

// >>> verification/gdo_cfg_properties.sv
// Concurrent checks on the ports of the gate drive configuration block.
`timescale 1ns/1ps
module gdo_cfg_properties #(
  parameter RETRY_LONG_CYC  = 1,
  parameter RETRY_SHORT_CYC = 1
) (
  // Clock, reset and register port.
  input wire        clk_i,
  input wire        rst_i,
  input wire [7:0]  reg_addr_i,
  input wire [7:0]  reg_wdata_i,
  input wire        reg_wr_i,
  input wire        write_locked_o,
  // Decoded settings and gates.
  input wire        fault_shutdown_o,
  input wire [3:0]  gate_o,
  input wire [3:0]  gate_oe_o,
  input wire [9:0]  high_side_source_ma_o,
  input wire [10:0] high_side_sink_ma_o,
  input wire [9:0]  low_side_source_ma_o,
  input wire [10:0] low_side_sink_ma_o,
  input wire [11:0] drain_source_trip_mv_o,
  input wire        comparator_one_hysteresis_o,
  input wire        post_fault_pulldown_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Write data one edge late, so a field can be matched after its write.
  reg  [7:0] wdata_r;
  wire       wr_ok = reg_wr_i && !write_locked_o;
  always @(posedge clk_i) wdata_r <= reg_wdata_i;

  // Sink current always doubles the source current.
  sink_double_a: assert property (
    high_side_sink_ma_o == {high_side_source_ma_o, 1'b0} && low_side_sink_ma_o == {low_side_source_ma_o, 1'b0})
    else $error("sink current not twice source");
  // Single-bit settings follow their register bit after a write.
  cmp_hyst_load_a: assert property (
    wr_ok && reg_addr_i == 8'h0A |=> comparator_one_hysteresis_o == wdata_r[7])
    else $error("hysteresis bit not loaded");
  pulldown_load_a: assert property (
    wr_ok && reg_addr_i == 8'h0B |=> post_fault_pulldown_select_o == wdata_r[3])
    else $error("pulldown bit not loaded");
  // Lock state and its effect on writes.
  lock_holds_a: assert property (
    write_locked_o && reg_wr_i && reg_addr_i == 8'h0A |=> $stable(comparator_one_hysteresis_o))
    else $error("locked write changed a register");
  lock_set_a: assert property (
    reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[6:4] == 3'h6 |=> write_locked_o)
    else $error("lock code did not lock");
  lock_clear_a: assert property (
    reg_wr_i && reg_addr_i == 8'h06 && reg_wdata_i[6:4] == 3'h3 |=> !write_locked_o)
    else $error("unlock code did not unlock");
  // Top codes of the decoded high-side source strength and trip level.
  hs_max_code_a: assert property (
    wr_ok && reg_addr_i == 8'h08 && reg_wdata_i[7:4] == 4'hF |=> ##1 high_side_source_ma_o == 10'h280)
    else $error("top drive code not 640 mA");
  trip_max_a: assert property (
    wr_ok && reg_addr_i == 8'h09 && reg_wdata_i[7:4] == 4'hF |=> ##1 drain_source_trip_mv_o == 12'h7D0)
    else $error("top trip code not 2000 mV");
  // Gates after a fault shutdown.
  shut_drive_low_a: assert property (
    fault_shutdown_o && post_fault_pulldown_select_o |=> gate_oe_o == 4'hF && gate_o == 4'h0)
    else $error("gates not driven low in shutdown");
  shut_float_a: assert property (
    fault_shutdown_o && !post_fault_pulldown_select_o |=> gate_oe_o == 4'h0)
    else $error("gates not released in shutdown");
  // Main scenarios.
  cover property (fault_shutdown_o && post_fault_pulldown_select_o);
  cover property (fault_shutdown_o && !post_fault_pulldown_select_o);
  cover property (write_locked_o && reg_wr_i);
endmodule // gdo_cfg_properties

// >>> verification/gdo_host.sv
// Host model driving the register port one strobe at a time.
`timescale 1ns/1ps
module gdo_host (
  // Clock and read data.
  input  wire       clk_i,
  input  wire [7:0] rdata_i,
  // Register strobes.
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o,
  output reg        wr_o,
  output reg        rd_o
);
  // Lock field value 011b that reopens the configuration registers.
  localparam [7:0] UNLOCK = 8'h30;
  // Idle bus at time zero.
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Strobe spans one edge; released lines show the inverse so stale values never pass.
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_i) #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i) #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // Read data is registered at the taking edge.
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clk_i) #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i) #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule // gdo_host

// >>> verification/testbench.sv
// Self-checking bench for the gate drive configuration block.
`timescale 1ns/1ps
module testbench;
  // Inputs driven by the bench.
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [5:0]  control_input_i = 6'h00;
  reg         sense_overcurrent_i = 1'b0;
  reg         drain_source_overcurrent_i = 1'b0;
  reg  [1:0]  sense_fault_response_i = 2'h0;
  reg  [1:0]  drain_fault_response_i = 2'h3;
  reg         clear_fault_i = 1'b0;
  // Register port and outputs.
  wire [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  wire        reg_wr_i, reg_rd_i, write_locked_o, fault_shutdown_o;
  wire [1:0]  fault_flag_o;
  wire [3:0]  gate_o, gate_oe_o;
  wire [9:0]  high_side_source_ma_o, low_side_source_ma_o;
  wire [10:0] high_side_sink_ma_o, low_side_sink_ma_o;
  wire [11:0] drain_source_trip_mv_o;
  wire        comparator_one_hysteresis_o, comparator_two_hysteresis_o;
  wire        supply_undervoltage_level_o, post_fault_pulldown_select_o;
  // Model state: register mirror, decode tables, deglitch cycles at 8 ns.
  int fail_count = 0;
  int compares = 0;
  int seed = 32'h8ccf;
  int m[4] = '{8'hFF, 8'h00, 8'h14, 8'h25};
  int ma[16] = '{50, 60, 70, 80, 100, 120, 140, 160, 200, 240, 280, 320, 400, 480, 560, 640};
  int mv[16] = '{40, 60, 80, 120, 160, 200, 240, 320, 400, 480, 600, 720, 960, 1200, 1600, 2000};
  int dg[4] = '{(1570 + 7) / 8, (2380 + 7) / 8, (3490 + 7) / 8, (5730 + 7) / 8};
  bit lk = 0;
  reg [7:0] d;
  int r;

  gdo_cfg #(.RETRY_LONG_CYC(50), .RETRY_SHORT_CYC(10)) uut (.*);
  gdo_host host (.clk_i, .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
                 .wr_o(reg_wr_i), .rd_o(reg_rd_i));

  // Free-running 125 MHz clock.
  always #4 clk_i = ~clk_i;

  task tick;
    @(posedge clk_i) #1;
  endtask
  task chk(input [11:0] got, input [11:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // Writes through the host and mirrors the effect in the model.
  task wreg(input [7:0] a, input [7:0] v);
    host.wr(a, v);
    if (a == 8'h06 && v[6:4] == 3'h6) lk = 1;
    if (a == 8'h06 && v[6:4] == 3'h3) lk = 0;
    if (!lk && a >= 8'h08 && a <= 8'h0B) m[a - 8] = v;
  endtask
  // Reads registers 08h to 0Bh back and compares the decoded settings.
  task chkall(input string what);
    for (int i = 0; i < 4; i++)
    begin
      host.rd(8'h08 + i, d);
      chk(d, m[i], what);
    end
    chk(high_side_source_ma_o, ma[m[0] >> 4], "hs source");
    chk(high_side_sink_ma_o, 2 * ma[m[0] >> 4], "hs sink");
    chk(low_side_source_ma_o, ma[m[0] & 15], "ls source");
    chk(low_side_sink_ma_o, 2 * ma[m[0] & 15], "ls sink");
    chk(drain_source_trip_mv_o, mv[m[1] >> 4], "trip");
    chk({comparator_two_hysteresis_o, comparator_one_hysteresis_o}, {m[3][7], m[2][7]}, "hyst");
    chk({post_fault_pulldown_select_o, supply_undervoltage_level_o}, {m[3][3], m[2][3]}, "bits");
    $display("test %s done", what);
  endtask
  // Raises one fault, measures deglitch, gate state and hold time.
  task trip(input bit snd, input int deg, input int hold);
    int n;
    n = 0;
    if (snd) sense_overcurrent_i = 1'b1;
    else drain_source_overcurrent_i = 1'b1;
    while (fault_shutdown_o !== 1'b1 && n < 2000)
    begin
      tick;
      n++;
    end
    chk(n >= deg + 1 && n <= deg + 5, 1, "deglitch");
    sense_overcurrent_i = 1'b0;
    drain_source_overcurrent_i = 1'b0;
    tick;
    chk({gate_oe_o, gate_o}, m[3][3] ? 8'hF0 : 8'h00, "shutdown gates");
    chk(fault_flag_o, snd ? 2'h1 : 2'h2, "fault flag");
    n = 0;
    while (fault_shutdown_o === 1'b1 && n < 300)
    begin
      tick;
      n++;
    end
    chk(n >= hold - 3 && n <= hold + 3, 1, "hold time");
    if (hold < 300)
      chk(fault_flag_o, 2'h0, "retry flag");
    $display("test fault done");
  endtask
  task report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    repeat (8) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chkall("reset");
    host.rd(8'h0C, d);
    chk(d, 0, "unmapped");
    for (int c = 0; c < 16; c++)
    begin
      wreg(8'h08, {c[3:0], ~c[3:0]});
      wreg(8'h09, (c << 4) | ($random(seed) & 15));
      chkall("drive code");
    end
    for (int c = 0; c < 8; c++)
    begin
      control_input_i = $random(seed);
      r = $random(seed);
      wreg(8'h0A, {r[7], c[2:0], r[3], c[2:0]});
      wreg(8'h0B, {r[6], c[2:0], 1'b0, c[2:0]});
      repeat (3) tick;
      for (int j = 0; j < 4; j++)
      begin
        chk(gate_oe_o[j], c != 7, "enable");
        if (c != 7) chk(gate_o[j], c == 0 ? 0 : control_input_i[c - 1], "level");
      end
      chkall("route code");
    end
    wreg(8'h06, 8'h60);
    chk(write_locked_o, 1, "locked");
    wreg(8'h0A, $random(seed));
    wreg(8'h06, 8'h50);
    chkall("locked write");
    wreg(8'h06, host.UNLOCK);
    chk(write_locked_o, 0, "unlocked");
    wreg(8'h0A, $random(seed));
    chkall("unlocked write");
    drain_fault_response_i = 2'h1;
    for (int i = 0; i < 4; i++)
    begin
      wreg(8'h0B, (m[3] & 8'hF7) | ((i & 2) << 2));
      wreg(8'h09, ((i & 1) << 2) | i);
      trip(0, dg[i], (i & 1) ? 10 : 50);
    end
    drain_fault_response_i = 2'h3;
    sense_fault_response_i = 2'h1;
    wreg(8'h09, 8'h08);
    trip(1, dg[0], 10);
    sense_fault_response_i = 2'h0;
    trip(1, dg[0], 300);
    clear_fault_i = 1'b1;
    tick;
    clear_fault_i = 1'b0;
    repeat (2) tick;
    chk({fault_shutdown_o, fault_flag_o}, 3'h0, "cleared");
    // Report-only sense fault beside a disabled drain fault: flag only, no shutdown.
    sense_fault_response_i = 2'h2;
    sense_overcurrent_i = 1'b1;
    drain_source_overcurrent_i = 1'b1;
    repeat (dg[0] + 8) tick;
    chk({fault_shutdown_o, fault_flag_o}, 3'h1, "report only");
    sense_overcurrent_i = 1'b0;
    drain_source_overcurrent_i = 1'b0;
    repeat (3) tick;
    clear_fault_i = 1'b1;
    tick;
    clear_fault_i = 1'b0;
    tick;
    chk(fault_flag_o, 2'h0, "report cleared");
    $display("test report done");
    report_and_stop;
  end

  // Watchdog far beyond the expected run length.
  initial
  begin
    #400000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop;
  end
endmodule // testbench

bind gdo_cfg gdo_cfg_properties #(.RETRY_LONG_CYC(RETRY_LONG_CYC), .RETRY_SHORT_CYC(RETRY_SHORT_CYC)) props (.*);
